// file: common/sdac_params.svh
// Offsets, field positions, reset values and timing counts of the converter control registers.
// Assumes a 32-bit bus where each register index maps to byte address four times the index.
`ifndef SDAC_PARAMS_SVH
`define SDAC_PARAMS_SVH

// Register indices; byte address is four times the index
`define SDAC_IDX_IRQ_EN_CLR   6'h05
`define SDAC_IDX_IRQ_EN_SET   6'h06
`define SDAC_IDX_IRQ_FLAGS    6'h07
`define SDAC_IDX_SEQ_STATE    6'h08
`define SDAC_IDX_INPUT_SEL    6'h09
`define SDAC_IDX_CONV_CTRL    6'h0a
`define SDAC_IDX_WIN_CTRL     6'h0b
`define SDAC_IDX_WIN_LOWER    6'h0c
`define SDAC_IDX_WIN_UPPER    6'h10
`define SDAC_IDX_RESULT       6'h1c
`define SDAC_IDX_COMMAND      6'h1d

// Interrupt bit positions
`define SDAC_BIT_RESULT_READY 0
`define SDAC_BIT_OVERRUN      1
`define SDAC_BIT_WINDOW_MATCH 2

// Field positions
`define SDAC_BIT_SEQ_BUSY     7
`define SDAC_BIT_CONTINUOUS   0
`define SDAC_BIT_START        0
`define SDAC_BIT_SYNC_BUSY    1

// Reset values
`define SDAC_RST_BYTE         8'h00
`define SDAC_RST_BOUND        24'h000000

// Window compare mode codes
`define SDAC_WIN_OFF          3'h0
`define SDAC_WIN_ABOVE        3'h1
`define SDAC_WIN_BELOW        3'h2
`define SDAC_WIN_INSIDE       3'h3
`define SDAC_WIN_OUTSIDE      3'h4

// Write synchronisation delay, in clock cycles
`define SDAC_SYNC_CYCLES      1

`endif

// file: common/sdac_pkg.sv
// Types shared by the converter control registers.
// Assumes the constants of sdac_params.svh are included where needed.
package sdac_pkg;

   // Sequencer states
   typedef enum logic [0:0] {
      SDAC_IDLE,
      SDAC_CONV
   } sdac_state_t;

   // Three interrupt sources: window match, overrun, result ready
   typedef logic [2:0] sdac_irq_t;

endpackage : sdac_pkg

// file: core/sdac_regs.sv
// Control and status registers of a sigma-delta converter, reached over classic Wishbone.
// Assumes the modulator hands over results as a one-cycle pulse on the same clock,
// and that the write guard comes from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "sdac_params.svh"

// What this block does
// R1: Writing one to an enable clear bit disables that interrupt; zero does nothing.
// R2: Writing one to an enable set bit enables that interrupt; zero does nothing.
// R3: Set and clear views read back one shared enable state.
// R4: Interrupt request is high in the cycle after each cycle in which any flag is set with its enable set.
// R5: Window match flag sets on the cycle after a matching result.
// R6: Window match and result ready clear on write-one or on result read.
// R7: Overrun sets when an unread result is overwritten; only write-one clears it.
// R8: Result ready sets as soon as a new result is stored.
// R9: Writing one to a flag clears it; zero leaves it alone.
// R10: Sequence busy sets when a sequence starts, clears at its last conversion when continuous conversion is off.
// R11: Four-bit sequence pointer shows the last completed conversion of the sequence.
// R12: Input pair select codes 0 to 2 pick a pair; 3 to 15 reserved.
// R13: Continuous bit zero gives single conversions; one restarts after each completion.
// R14: Window modes: 0 off, 1 above lower, 2 below upper.
// R15: Window modes: 3 strictly inside, 4 strictly outside, 5 to 7 reserved.
// R16: Lower bound holds 24 bits used by the window comparison.
// R17: Guarded configuration writes are blocked by the guard and synchronised.
// R18: Upper bound holds 24 bits used by the window comparison.
// R19: Reserved window modes never set the window match flag.
module sdac_regs #(
   parameter int SEQ_LEN = 1
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        write_guard_i,
   input  wire logic        conv_done_i,
   input  wire logic [23:0] conv_result_i,
   output logic             conv_start_o,
   output logic [3:0]       input_pair_select_o,
   output logic             irq_o
);

   localparam logic [3:0] LAST_IDX = 4'(SEQ_LEN - 1);

   // Bus decode
   logic [5:0]              idx;
   logic                    req;
   logic                    wr;
   logic                    rd_result;
   assign idx       = wb_adr_i[7:2];
   assign req       = wb_cyc_i & wb_stb_i;
   // Writes land on the edge where the master sees ack high
   assign wr        = req & wb_we_i & wb_ack_o & wb_sel_i[0];
   // Read side effects happen once, on the cycle the answer is formed
   assign rd_result = req & ~wb_we_i & ~wb_ack_o & (idx == `SDAC_IDX_RESULT);

   // Registers
   sdac_pkg::sdac_irq_t     irq_enable;
   sdac_pkg::sdac_irq_t     irq_flags;
   logic [3:0]              input_pair_select;
   logic                    continuous_conversion;
   logic [2:0]              window_compare_mode;
   logic [23:0]             window_lower_bound;
   logic [23:0]             window_upper_bound;
   logic [23:0]             result;
   logic                    result_unread;
   logic                    sync_busy;
   logic                    start_cmd;
   // Converter-side copies, loaded through write synchronisation
   logic                    cs_continuous;
   logic [2:0]              cs_mode;
   logic [23:0]             cs_lower;
   logic [23:0]             cs_upper;
   // Sequencer
   sdac_pkg::sdac_state_t   state;
   logic                    sequence_busy;
   logic [3:0]              sequence_pointer;
   logic [3:0]              conv_count;
   logic                    win_hit;
   logic                    guarded_ok;

   // Writes to guarded registers only pass when the guard is open
   assign guarded_ok = wr & ~write_guard_i;

   // Byte-lane merge for the threshold words
   function automatic logic [23:0] merge24(input logic [23:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0]  s);
      logic [23:0] r;
      r = old;
      if (s[0]) r[7:0]   = d[7:0];
      if (s[1]) r[15:8]  = d[15:8];
      if (s[2]) r[23:16] = d[23:16];
      return r;
   endfunction : merge24

   // Window comparison on a fresh result; reserved codes never match
   always_comb begin
      case (cs_mode)
         `SDAC_WIN_ABOVE:   win_hit = conv_result_i > cs_lower;                   // R14 R16
         `SDAC_WIN_BELOW:   win_hit = conv_result_i < cs_upper;                   // R14 R18
         `SDAC_WIN_INSIDE:  win_hit = (conv_result_i > cs_lower) &
                                      (conv_result_i < cs_upper);                  // R15
         `SDAC_WIN_OUTSIDE: win_hit = (conv_result_i < cs_lower) |
                                      (conv_result_i > cs_upper);                  // R15
         default:           win_hit = 1'b0;                                        // R19
      endcase
   end

   // Shared enable state behind the set and clear views
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_enable <= 3'h0;
      end else if (guarded_ok && idx == `SDAC_IDX_IRQ_EN_SET) begin
         irq_enable <= irq_enable | wb_dat_i[2:0];                                // R2 R3
      end else if (guarded_ok && idx == `SDAC_IDX_IRQ_EN_CLR) begin
         irq_enable <= irq_enable & ~wb_dat_i[2:0];                               // R1 R3
      end
   end

   // Flag events: conversions set, write-one and result reads clear;
   // overrun ignores reads so software always learns of a lost result
   logic [2:0]              flag_set;
   logic [2:0]              flag_clr;
   assign flag_set[`SDAC_BIT_RESULT_READY] = conv_done_i;                         // R8
   assign flag_set[`SDAC_BIT_OVERRUN]      = conv_done_i & result_unread;         // R7
   assign flag_set[`SDAC_BIT_WINDOW_MATCH] = conv_done_i & win_hit;               // R5
   assign flag_clr = ({3{wr && idx == `SDAC_IDX_IRQ_FLAGS}} & wb_dat_i[2:0]) |    // R9
                     {rd_result, 1'b0, rd_result};                                 // R6

   // Interrupt flags; a hardware set wins over a same-cycle clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_flags <= 3'h0;
      end else begin
         irq_flags <= flag_set | (irq_flags & ~flag_clr);
      end
   end

   // Interrupt request from flags gated by enables
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(irq_flags & irq_enable);                                       // R4
      end
   end

   // Result store and unread tracking
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         result        <= 24'h000000;
         result_unread <= 1'b0;
      end else if (conv_done_i) begin
         result        <= conv_result_i;
         result_unread <= 1'b1;
      end else if (rd_result) begin
         result_unread <= 1'b0;
      end
   end

   // Guarded configuration registers, bus side
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         input_pair_select     <= 4'h0;
         continuous_conversion <= 1'b0;
         window_compare_mode   <= 3'h0;
         window_lower_bound    <= `SDAC_RST_BOUND;
         window_upper_bound    <= `SDAC_RST_BOUND;
      end else if (guarded_ok) begin                                               // R17
         case (idx)
            `SDAC_IDX_INPUT_SEL: input_pair_select     <= wb_dat_i[3:0];          // R12
            `SDAC_IDX_CONV_CTRL: continuous_conversion <= wb_dat_i[0];
            `SDAC_IDX_WIN_CTRL:  window_compare_mode   <= wb_dat_i[2:0];
            `SDAC_IDX_WIN_LOWER: window_lower_bound    <=
               merge24(window_lower_bound, wb_dat_i, wb_sel_i);                    // R16
            `SDAC_IDX_WIN_UPPER: window_upper_bound    <=
               merge24(window_upper_bound, wb_dat_i, wb_sel_i);                    // R18
            default: ;
         endcase
      end
   end

   // Write synchronisation: converter copies follow a cycle later,
   // so a comparison never sees half of a threshold update
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync_busy           <= 1'b0;
         cs_continuous       <= 1'b0;
         cs_mode             <= 3'h0;
         cs_lower            <= `SDAC_RST_BOUND;
         cs_upper            <= `SDAC_RST_BOUND;
         input_pair_select_o <= 4'h0;
      end else begin
         sync_busy <= guarded_ok && (idx >= `SDAC_IDX_INPUT_SEL) &&
                      (idx <= `SDAC_IDX_WIN_UPPER);                                // R17
         if (sync_busy) begin
            cs_continuous       <= continuous_conversion;
            cs_mode             <= window_compare_mode;
            cs_lower            <= window_lower_bound;
            cs_upper            <= window_upper_bound;
            input_pair_select_o <= input_pair_select;                              // R12
         end
      end
   end

   // Software start command, a one-cycle request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         start_cmd <= 1'b0;
      end else begin
         start_cmd <= wr && idx == `SDAC_IDX_COMMAND && wb_dat_i[`SDAC_BIT_START];
      end
   end

   // Sequencer: busy span, pointer and automatic restarts
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state            <= sdac_pkg::SDAC_IDLE;
         sequence_busy    <= 1'b0;
         sequence_pointer <= 4'h0;
         conv_count       <= 4'h0;
         conv_start_o     <= 1'b0;
      end else begin
         conv_start_o <= 1'b0;
         case (state)
            sdac_pkg::SDAC_IDLE: begin
               if (start_cmd) begin
                  state         <= sdac_pkg::SDAC_CONV;
                  sequence_busy <= 1'b1;                                           // R10
                  conv_count    <= 4'h0;
                  conv_start_o  <= 1'b1;
               end
            end
            sdac_pkg::SDAC_CONV: begin
               if (conv_done_i) begin
                  sequence_pointer <= conv_count;                                  // R11
                  if (conv_count == LAST_IDX) begin
                     conv_count <= 4'h0;
                     if (cs_continuous) begin
                        conv_start_o <= 1'b1;                                      // R13
                     end else begin
                        state         <= sdac_pkg::SDAC_IDLE;
                        sequence_busy <= 1'b0;                                     // R10
                     end
                  end else begin
                     conv_count   <= conv_count + 4'h1;
                     conv_start_o <= 1'b1;
                  end
               end
            end
            default: state <= sdac_pkg::SDAC_IDLE;
         endcase
      end
   end

   // Read mux; unmapped addresses read zero
   function automatic logic [31:0] read_word(input logic [5:0] a);
      case (a)
         `SDAC_IDX_IRQ_EN_CLR,
         `SDAC_IDX_IRQ_EN_SET: read_word = {29'h0, irq_enable};                   // R3
         `SDAC_IDX_IRQ_FLAGS:  read_word = {29'h0, irq_flags};
         `SDAC_IDX_SEQ_STATE:  read_word = {24'h0, sequence_busy, 3'h0,
                                            sequence_pointer};                     // R11
         `SDAC_IDX_INPUT_SEL:  read_word = {28'h0, input_pair_select};
         `SDAC_IDX_CONV_CTRL:  read_word = {31'h0, continuous_conversion};
         `SDAC_IDX_WIN_CTRL:   read_word = {29'h0, window_compare_mode};
         `SDAC_IDX_WIN_LOWER:  read_word = {8'h0, window_lower_bound};
         `SDAC_IDX_WIN_UPPER:  read_word = {8'h0, window_upper_bound};
         `SDAC_IDX_RESULT:     read_word = {8'h0, result};
         `SDAC_IDX_COMMAND:    read_word = {30'h0, sync_busy, 1'b0};
         default:              read_word = 32'h0;
      endcase
   endfunction : read_word

   // Wishbone answer: ack one cycle after the request, dropped the next
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= req & ~wb_ack_o;
         if (req && !wb_ack_o && !wb_we_i) begin
            wb_dat_o <= read_word(idx);
         end
      end
   end

   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_clr_write;
      wr && idx == `SDAC_IDX_IRQ_EN_CLR && !write_guard_i;
   endsequence
   sequence s_set_write;
      wr && idx == `SDAC_IDX_IRQ_EN_SET && !write_guard_i;
   endsequence

   a_enable_clear: assert property (s_clr_write |=> // R1
                                    ((irq_enable & $past(wb_dat_i[2:0])) == 3'h0))
      else $error("enable clear left a bit set");
   a_enable_set: assert property (s_set_write |=> // R2
                                  ((~irq_enable & $past(wb_dat_i[2:0])) == 3'h0))
      else $error("enable set left a bit clear");
   a_enable_keep: assert property ( // R3
      !(wr && !write_guard_i &&
        (idx == `SDAC_IDX_IRQ_EN_CLR || idx == `SDAC_IDX_IRQ_EN_SET))
      |=> $stable(irq_enable))
      else $error("enable changed without a write");
   a_irq_request: assert property ((|(irq_flags & irq_enable)) |=> irq_o) // R4
      else $error("interrupt request missing");
   a_win_flag: assert property (conv_done_i && win_hit |=> irq_flags[2]) // R5
      else $error("window match flag not set");
   a_read_clears: assert property (rd_result && !conv_done_i |=> // R6
                                   !irq_flags[0] && !irq_flags[2])
      else $error("result read did not clear flags");
   a_overrun: assert property (conv_done_i && result_unread |=> irq_flags[1]) // R7
      else $error("overrun not flagged");
   a_overrun_hold: assert property (irq_flags[1] && !(wr && idx == `SDAC_IDX_IRQ_FLAGS) // R7
                                    |=> irq_flags[1])
      else $error("overrun cleared without write");
   a_ready_set: assert property (conv_done_i |=> // R8
                                 irq_flags[0] && result == $past(conv_result_i))
      else $error("result ready not set");
   a_busy_start: assert property (state == sdac_pkg::SDAC_IDLE && start_cmd // R10
                                  |=> sequence_busy ##0 conv_start_o)
      else $error("sequence did not start");
   a_reserved_mode: assert property (cs_mode > `SDAC_WIN_OUTSIDE |-> !win_hit) // R19
      else $error("reserved mode matched");
   a_guard_block: assert property (wr && write_guard_i |=> !sync_busy ##1 $stable(cs_lower)) // R17
      else $error("guarded write got through");

endmodule : sdac_regs
`default_nettype wire

// file: testbench/test_sigma_delta_adc_ctrl_regs.sv
// Self-checking bench for the converter control registers.
// Assumes sdac_regs answers every Wishbone request one cycle later, and plays the modulator itself.
`timescale 1ns/100ps
`default_nettype none
`include "sdac_params.svh"

module test_sigma_delta_adc_ctrl_regs;
   logic        clk, rst, cyc, stb, we, guard, done;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat;
   logic [23:0] res;
   logic [31:0] rdat;
   logic        ack, start, irq;
   logic [3:0]  pair;
   int          n_mismatch;
   int          comparisons;
   logic [31:0] v;

   sdac_regs #(.SEQ_LEN(1)) DUT (
      .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .write_guard_i(guard), .conv_done_i(done), .conv_result_i(res),
      .conv_start_o(start), .input_pair_select_o(pair), .irq_o(irq));

   // 50 MHz clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Verdict and end of run, reached from the main sequence or a timeout
   task automatic stop_test();
      $display("checks %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : stop_test

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
         n_mismatch++;
      end
   endtask : check

   // Classic cycle; held until ack is sampled high, then released for at least one cycle
   task automatic wb_cycle(input logic w, input logic [5:0] idx, input logic [31:0] d,
                           output logic [31:0] q);
      int n;
      @(posedge clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= {idx, 2'b00};
      sel  <= 4'hf;
      wdat <= d;
      for (n = 0; n < 20; n++) begin
         @(posedge clk);
         if (ack === 1'b1) break;
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
      if (n == 20) begin
         $display("[ERR] bus ack timed out");
         n_mismatch++;
         stop_test();
      end
   endtask : wb_cycle

   task automatic wr(input logic [5:0] idx, input logic [31:0] d);
      logic [31:0] q;
      wb_cycle(1'b1, idx, d, q);
   endtask : wr

   task automatic rd(input logic [5:0] idx, output logic [31:0] q);
      wb_cycle(1'b0, idx, 32'h0, q);
   endtask : rd

   // Waits for one start pulse; a missing pulse ends the run
   task automatic wait_start();
      int n;
      for (n = 0; n < 20; n++) begin
         @(posedge clk);
         if (start === 1'b1) break;
      end
      if (n == 20) begin
         $display("[ERR] conversion start timed out");
         n_mismatch++;
         stop_test();
      end
   endtask : wait_start

   // Start command, then the modulator hands back one result
   task automatic conv(input logic [23:0] r);
      wr(`SDAC_IDX_COMMAND, 32'h1);
      wait_start();
      @(posedge clk);
      done <= 1'b1;
      res  <= r;
      @(posedge clk);
      done <= 1'b0;
      res  <= 24'h000000;
      repeat (2) @(posedge clk);
   endtask : conv

   task automatic t_reset_values();
      logic [5:0] idx [7] = '{6'h05, 6'h06, 6'h07, 6'h08, 6'h09, 6'h0a, 6'h0b};
      foreach (idx[i]) begin
         rd(idx[i], v);
         check("reset byte", v, 32'h0);
      end
      rd(`SDAC_IDX_WIN_LOWER, v);
      check("reset lower", v, 32'h0);
      rd(`SDAC_IDX_WIN_UPPER, v);
      check("reset upper", v, 32'h0);
      rd(6'h3f, v);
      check("unmapped read", v, 32'h0);
      $display("test reset values done");
   endtask : t_reset_values

   task automatic t_enables();
      wr(`SDAC_IDX_IRQ_EN_SET, 32'h5);
      rd(`SDAC_IDX_IRQ_EN_CLR, v);
      check("enable clear view", v, 32'h5);
      wr(`SDAC_IDX_IRQ_EN_SET, 32'h0);
      rd(`SDAC_IDX_IRQ_EN_SET, v);
      check("enable set zero", v, 32'h5);
      wr(`SDAC_IDX_IRQ_EN_CLR, 32'h1);
      rd(`SDAC_IDX_IRQ_EN_SET, v);
      check("enable set view", v, 32'h4);
      wr(`SDAC_IDX_IRQ_EN_CLR, 32'h0);
      rd(`SDAC_IDX_IRQ_EN_CLR, v);
      check("enable clear zero", v, 32'h4);
      wr(`SDAC_IDX_IRQ_EN_CLR, 32'h4);
      rd(`SDAC_IDX_IRQ_EN_SET, v);
      check("enable all off", v, 32'h0);
      $display("test enables done");
   endtask : t_enables

   task automatic t_single();
      wr(`SDAC_IDX_IRQ_EN_SET, 32'h1);
      wr(`SDAC_IDX_COMMAND, 32'h1);
      wait_start();
      rd(`SDAC_IDX_SEQ_STATE, v);
      check("busy while running", v[7], 1'b1);
      @(posedge clk);
      done <= 1'b1;
      res  <= 24'habcdef;
      @(posedge clk);
      done <= 1'b0;
      // A restart would show in exactly this cycle
      @(posedge clk);
      check("no restart when single", start, 1'b0);
      @(posedge clk);
      check("irq on ready", irq, 1'b1);
      rd(`SDAC_IDX_IRQ_FLAGS, v);
      check("ready flag", v, 32'h1);
      rd(`SDAC_IDX_SEQ_STATE, v);
      check("sequence state", v, 32'h0);
      rd(`SDAC_IDX_RESULT, v);
      check("result value", v, 32'h00abcdef);
      repeat (2) @(posedge clk);
      check("irq after read", irq, 1'b0);
      rd(`SDAC_IDX_IRQ_FLAGS, v);
      check("ready cleared by read", v, 32'h0);
      wr(`SDAC_IDX_IRQ_EN_CLR, 32'h7);
      $display("test single done");
   endtask : t_single

   task automatic t_overrun();
      wr(`SDAC_IDX_IRQ_EN_SET, 32'h2);
      conv(24'h000011);
      conv(24'h000022);
      check("irq on overrun", irq, 1'b1);
      rd(`SDAC_IDX_RESULT, v);
      rd(`SDAC_IDX_IRQ_FLAGS, v);
      check("overrun survives read", v, 32'h2);
      wr(`SDAC_IDX_IRQ_FLAGS, 32'h0);
      rd(`SDAC_IDX_IRQ_FLAGS, v);
      check("flag write zero", v, 32'h2);
      wr(`SDAC_IDX_IRQ_FLAGS, 32'h2);
      rd(`SDAC_IDX_IRQ_FLAGS, v);
      check("overrun cleared", v, 32'h0);
      check("irq released", irq, 1'b0);
      wr(`SDAC_IDX_IRQ_EN_CLR, 32'h7);
      $display("test overrun done");
   endtask : t_overrun

   task automatic t_continuous_conversion();
      wr(`SDAC_IDX_CONV_CTRL, 32'h1);
      wr(`SDAC_IDX_COMMAND, 32'h1);
      wait_start();
      @(posedge clk);
      done <= 1'b1;
      res  <= 24'h000033;
      @(posedge clk);
      done <= 1'b0;
      res  <= 24'h000000;
      // The restart pulse stands for one cycle right after the result
      @(posedge clk);
      check("automatic restart", start, 1'b1);
      wr(`SDAC_IDX_CONV_CTRL, 32'h0);
      repeat (3) @(posedge clk);
      done <= 1'b1;
      @(posedge clk);
      done <= 1'b0;
      @(posedge clk);
      check("no restart after stop", start, 1'b0);
      repeat (3) @(posedge clk);
      rd(`SDAC_IDX_SEQ_STATE, v);
      check("sequence ended", v, 32'h0);
      rd(`SDAC_IDX_RESULT, v);
      wr(`SDAC_IDX_IRQ_FLAGS, 32'h7);
      $display("test free run done");
   endtask : t_continuous_conversion

   // Every mode against results on and either side of both bounds
   task automatic t_window();
      int          lo = 100;
      int          hi = 200;
      int          r [5] = '{50, 100, 150, 200, 250};
      logic        e;
      wr(`SDAC_IDX_WIN_LOWER, 32'hff000064);
      wr(`SDAC_IDX_WIN_UPPER, 32'hff0000c8);
      rd(`SDAC_IDX_WIN_LOWER, v);
      check("lower width", v, 32'h00000064);
      for (int m = 0; m < 8; m++) begin
         wr(`SDAC_IDX_WIN_CTRL, m);
         foreach (r[i]) begin
            case (m)
               1: e = r[i] > lo;
               2: e = r[i] < hi;
               3: e = r[i] > lo && r[i] < hi;
               4: e = r[i] > hi || r[i] < lo;
               default: e = 1'b0;
            endcase
            conv(r[i][23:0]);
            rd(`SDAC_IDX_IRQ_FLAGS, v);
            check("window match", v[2], e);
            rd(`SDAC_IDX_RESULT, v);
            rd(`SDAC_IDX_IRQ_FLAGS, v);
            check("window cleared by read", v[2], 1'b0);
         end
      end
      $display("test window done");
   endtask : t_window

   task automatic t_guard_and_select();
      guard <= 1'b1;
      wr(`SDAC_IDX_INPUT_SEL, 32'h2);
      wr(`SDAC_IDX_IRQ_EN_SET, 32'h7);
      rd(`SDAC_IDX_INPUT_SEL, v);
      check("guarded select", v, 32'h0);
      rd(`SDAC_IDX_IRQ_EN_SET, v);
      check("guarded enable", v, 32'h0);
      guard <= 1'b0;
      for (int c = 2; c >= 0; c--) begin
         wr(`SDAC_IDX_INPUT_SEL, c);
         repeat (3) @(posedge clk);
         check("pair select pin", pair, c[3:0]);
      end
      $display("test guard and select done");
   endtask : t_guard_and_select

   // Main sequence
   initial begin
      rst   = 1'b1;
      cyc   = 1'b0;
      stb   = 1'b0;
      we    = 1'b0;
      adr   = 8'h00;
      sel   = 4'h0;
      wdat  = 32'h0;
      guard = 1'b0;
      done  = 1'b0;
      res   = 24'h000000;
      n_mismatch = 0;
      comparisons = 0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_reset_values();
      t_enables();
      t_single();
      t_overrun();
      t_continuous_conversion();
      t_window();
      t_guard_and_select();
      stop_test();
   end
endmodule : test_sigma_delta_adc_ctrl_regs
`default_nettype wire
